// File: rtl/tbam_consts.vh
// Constants of the two-wire address-match and bus-condition block.
// Assumes inclusion by rtl/tbam_core.v only; definitions only.
`ifndef TBAM_CONSTS_VH
`define TBAM_CONSTS_VH
// ****************************************
// Detection thresholds, CLOCK cycles
// ****************************************
`define TBAM_STD_REL_CYC   8'd65
// Counts are whole cycles compared with '>': more than 32 whole is more than 32.5
`define TBAM_STD_SH_CYC    8'd32
`define TBAM_HS_REL_CYC    8'd10
`define TBAM_HS_SH_CYC     8'd5
// ****************************************
// Register command values
// ****************************************
`define TBAM_ST_START      8'hf0
`define TBAM_ST_STOP       8'hd0
`define TBAM_ST_IDLE       8'h10
`define TBAM_CTL_ENABLE    8'h08
`define TBAM_CCR_STD_ACK   8'h85
`define TBAM_CCR_FAST_NACK 8'h25
// ****************************************
// Field positions, reset values and SCL half-period lengths
// ****************************************
`define TBAM_ST_MST_BIT    7
`define TBAM_ST_BB_BIT     5
`define TBAM_CTL_EN_BIT    3
`define TBAM_CTL_10B_BIT   4
`define TBAM_CCR_ACK_BIT   7
`define TBAM_CCR_FAST_BIT  5
`define TBAM_OWN_RST       8'h00
`define TBAM_CTL_RST       8'h00
`define TBAM_CCR_RST       8'h00
`define TBAM_SCL_HALF_STD  8'd50
`define TBAM_SCL_HALF_FAST 8'd13
`endif

// File: rtl/tbam_core.v
// Two-wire bus engine: START/STOP detection, 7-bit or full 8-bit address match,
// general call, master START/byte/STOP generation, byte-wide registers.
// Assumes SCL/SDA inputs are asynchronous pins; open-drain via *_OE.
`timescale 1ns/1ps
`include "tbam_consts.vh"
module tbam_core #(
   parameter DW = 8
)(
   input  wire          CLOCK,
   input  wire          SRST,
   input  wire          CE,
   input  wire          SCL_IN,
   output wire          SCL_OUT,
   output wire          SCL_OE,
   input  wire          SDA_IN,
   output wire          SDA_OUT,
   output wire          SDA_OE,
   input  wire [2:0]    REG_SEL,
   input  wire          REG_WR,
   input  wire [DW-1:0] REG_WDATA,
   output reg  [DW-1:0] REG_RDATA,
   output wire          RX_VALID,
   input  wire          RX_READY,
   output wire [DW-1:0] RX_DATA,
   output wire          SERIAL_IRQ
);
// ****************************************
// Register select codes
// ****************************************
localparam [2:0] R_SHIFT = 3'd0, R_OWN = 3'd1, R_STAT = 3'd2, R_CTL = 3'd3,
                 R_CCR = 3'd4, R_PORT = 3'd5, R_TXB = 3'd6;
localparam [4:0] S_IDLE = 5'b00001, S_START = 5'b00010, S_BIT = 5'b00100,
                 S_ACK = 5'b01000, S_STOP = 5'b10000;
// ****************************************
// Pin synchronisers and filter counters
// ****************************************
reg  [1:0] scl_s_r, sda_s_r;
reg        scl_q_r, sda_q_r;
reg  [7:0] scl_hi_r, sda_st_r;
always @(posedge CLOCK)
   if (SRST)
   begin
      scl_s_r <= 2'b11;
      sda_s_r <= 2'b11;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      scl_hi_r <= 8'h00;
      sda_st_r <= 8'h00;
   end
   else if (CE)
   begin
      scl_s_r <= {scl_s_r[0], SCL_IN};
      sda_s_r <= {sda_s_r[0], SDA_IN};
      scl_q_r <= scl_s_r[1];
      sda_q_r <= sda_s_r[1];
      scl_hi_r <= !scl_s_r[1] ? 8'h00 : (scl_hi_r == 8'hff ? scl_hi_r : scl_hi_r + 8'd1);
      sda_st_r <= (sda_s_r[1] != sda_q_r) ? 8'h00 : (sda_st_r == 8'hff ? sda_st_r : sda_st_r + 8'd1);
   end
wire scl = scl_s_r[1];
wire sda = sda_s_r[1];
reg  [7:0] own_r, ctl_r, ccr_r, port_r, shift_r, stat_r;
wire       fast = ccr_r[`TBAM_CCR_FAST_BIT];
wire       ack_mode = ccr_r[`TBAM_CCR_ACK_BIT];
wire [7:0] rel_min = fast ? `TBAM_HS_REL_CYC : `TBAM_STD_REL_CYC;
wire [7:0] sh_min = fast ? `TBAM_HS_SH_CYC : `TBAM_STD_SH_CYC;
// Setup: SDA steady before its edge; hold: SCL stays high past the edge
wire       sda_edge = scl && scl_q_r && (sda != sda_q_r)
                      && (scl_hi_r > rel_min) && (sda_st_r > sh_min);
reg        pend_start_r, pend_stop_r;
reg  [7:0] hold_r;
wire       hold_ok = (hold_r > sh_min);
wire       det_start = pend_start_r && hold_ok;
wire       det_stop = pend_stop_r && hold_ok;
always @(posedge CLOCK)
   if (SRST)
   begin
      pend_start_r <= 1'b0;
      pend_stop_r <= 1'b0;
      hold_r <= 8'h00;
   end
   else if (CE)
   begin
      if (sda_edge)
      begin
         pend_start_r <= !sda;
         pend_stop_r <= sda;
         hold_r <= 8'h00;
      end
      else if (!scl || det_start || det_stop || (sda != sda_q_r))
      begin
         pend_start_r <= 1'b0;
         pend_stop_r <= 1'b0;
      end
      else
         hold_r <= hold_r + 8'd1;
   end
// ****************************************
// Receive/transmit engine
// ****************************************
wire       enabled = ctl_r[`TBAM_CTL_EN_BIT];
wire       scl_rise = scl && !scl_q_r;
wire       scl_fall = !scl && scl_q_r;
reg  [4:0] state_r;
reg  [2:0] bc_r;
reg        addr_phase_r, aas_r, gc_r, irq_r, mst_r, bb_r, ack_pend_r, stop_req_r;
reg        sda_drv_r, scl_drv_r, nack_r;
reg  [7:0] half_r;
reg        buf_vld_r;
reg  [7:0] rx_byte_r, buf0_r, buf1_r;
reg  [1:0] fill_r;
wire       rx_push;
wire       rx_can = (fill_r != 2'd2);
wire [7:0] half_lim = fast ? `TBAM_SCL_HALF_FAST : `TBAM_SCL_HALF_STD;
wire [7:0] rcv = {shift_r[6:0], sda};
wire       gc_hit = (rcv == 8'h00);
wire       a_hit = ctl_r[`TBAM_CTL_10B_BIT] ? (rcv == own_r)
                                            : (rcv[7:1] == own_r[7:1]);
wire       wr = REG_WR && CE;
always @(posedge CLOCK)
   if (SRST)
   begin
      state_r <= S_IDLE;
      bc_r <= 3'd0;
      addr_phase_r <= 1'b0;
      aas_r <= 1'b0;
      gc_r <= 1'b0;
      irq_r <= 1'b0;
      mst_r <= 1'b0;
      bb_r <= 1'b0;
      ack_pend_r <= 1'b0;
      stop_req_r <= 1'b0;
      sda_drv_r <= 1'b0;
      scl_drv_r <= 1'b0;
      nack_r <= 1'b0;
      half_r <= 8'h00;
      shift_r <= 8'h00;
      own_r <= `TBAM_OWN_RST;
      ctl_r <= `TBAM_CTL_RST;
      ccr_r <= `TBAM_CCR_RST;
      port_r <= 8'h00;
      buf_vld_r <= 1'b0;
      rx_byte_r <= 8'h00;
   end
   else if (CE)
   begin
      irq_r <= 1'b0;
      buf_vld_r <= 1'b0;
      if (wr && REG_SEL == R_OWN) own_r <= REG_WDATA;
      if (wr && REG_SEL == R_CTL) ctl_r <= REG_WDATA;
      if (wr && REG_SEL == R_CCR) ccr_r <= REG_WDATA;
      if (wr && REG_SEL == R_PORT) port_r <= {4'h0, REG_WDATA[3:0]};
      if (wr && (REG_SEL == R_SHIFT || REG_SEL == R_TXB))
      begin
         shift_r <= REG_WDATA;
         aas_r <= 1'b0;
      end
      if (wr && REG_SEL == R_STAT)
      begin
         if (REG_WDATA == `TBAM_ST_START && enabled && !bb_r)
         begin
            mst_r <= 1'b1;
            state_r <= S_START;
            half_r <= 8'h00;
         end
         else if (REG_WDATA == `TBAM_ST_START && enabled && mst_r)
         begin
            state_r <= S_START;
            half_r <= 8'h00;
         end
         if (REG_WDATA == `TBAM_ST_STOP && mst_r) stop_req_r <= 1'b1;
      end
      if (!enabled)
      begin
         bb_r <= 1'b0;
         state_r <= S_IDLE;
         mst_r <= 1'b0;
      end
      else if (det_start)
      begin
         bb_r <= 1'b1;
         bc_r <= 3'd0;
         addr_phase_r <= !mst_r;
      end
      else if (det_stop)
      begin
         bb_r <= 1'b0;
         own_r[0] <= 1'b0;
         if (!mst_r) irq_r <= 1'b1;
         mst_r <= 1'b0;
         stop_req_r <= 1'b0;
         addr_phase_r <= 1'b0;
         state_r <= S_IDLE;
      end
      else if (!mst_r && scl_rise && !ack_pend_r && rx_can)
      begin
         shift_r <= rcv;
         bc_r <= bc_r + 3'd1;
         if (bc_r == 3'd7)
         begin
            ack_pend_r <= ack_mode;
            if (addr_phase_r)
            begin
               addr_phase_r <= 1'b0;
               gc_r <= gc_hit;
               aas_r <= a_hit && !gc_hit;
               irq_r <= gc_hit || a_hit;
            end
            else
            begin
               irq_r <= 1'b1;
               buf_vld_r <= 1'b1;
               rx_byte_r <= rcv;
            end
         end
      end
      else if (!mst_r && ack_pend_r && scl_fall)
         ack_pend_r <= 1'b0;
      // Master side: drive SCL low and let it float for each half period
      if (enabled && mst_r && state_r != S_IDLE)
      begin
         half_r <= (half_r == half_lim) ? 8'h00 : half_r + 8'd1;
         // Data moves only mid-way through the low phase, clear of both SCL edges
         if (scl_drv_r && half_r == {1'b0, half_lim[7:1]} && state_r != S_START)
            sda_drv_r <= (state_r == S_BIT) ? !shift_r[7] : (state_r == S_STOP);
         if (half_r == half_lim)
            case (state_r)
               S_START:
                  if (scl_drv_r)
                  begin
                     sda_drv_r <= 1'b0;
                     scl_drv_r <= 1'b0;
                  end
                  else if (!sda_drv_r)
                     sda_drv_r <= (scl_hi_r > rel_min);
                  else
                  begin
                     scl_drv_r <= 1'b1;
                     bc_r <= 3'd0;
                     state_r <= S_BIT;
                  end
               S_BIT:
                  if (scl_drv_r)
                     scl_drv_r <= 1'b0;
                  else
                  begin
                     shift_r <= {shift_r[6:0], sda};
                     scl_drv_r <= 1'b1;
                     bc_r <= bc_r + 3'd1;
                     if (bc_r == 3'd7) state_r <= S_ACK;
                  end
               S_ACK:
                  if (scl_drv_r)
                     scl_drv_r <= 1'b0;
                  else
                  begin
                     nack_r <= sda;
                     scl_drv_r <= 1'b1;
                     irq_r <= 1'b1;
                     state_r <= (stop_req_r || sda) ? S_STOP : S_IDLE;
                  end
               // SDA is released only once SCL has been high long enough to count as STOP
               S_STOP:
                  if (scl_drv_r) scl_drv_r <= 1'b0;
                  else if (scl_hi_r > rel_min)
                  begin
                     sda_drv_r <= 1'b0;
                     stop_req_r <= 1'b0;
                     state_r <= S_IDLE;
                  end
               default: state_r <= S_IDLE;
            endcase
      end
      else if (!mst_r)
      begin
         scl_drv_r <= 1'b0;
         sda_drv_r <= ack_pend_r && (aas_r || gc_r || !addr_phase_r) && !scl_rise;
      end
   end
// ****************************************
// Status word and register read path
// ****************************************
always @*
begin
   stat_r = {mst_r, mst_r, bb_r, !irq_r, 1'b0, gc_r, aas_r, nack_r};
   case (REG_SEL)
      R_SHIFT: REG_RDATA = shift_r;
      R_OWN:   REG_RDATA = own_r;
      R_STAT:  REG_RDATA = stat_r;
      R_CTL:   REG_RDATA = {ctl_r[7:3], bc_r};
      R_CCR:   REG_RDATA = ccr_r;
      R_PORT:  REG_RDATA = {shift_r[7:4], port_r[3:0]};
      default: REG_RDATA = 8'h00;
   endcase
end
assign SCL_OUT = 1'b0;
assign SDA_OUT = 1'b0;
assign SCL_OE = scl_drv_r || (!mst_r && !rx_can);
assign SDA_OE = sda_drv_r;
assign SERIAL_IRQ = irq_r;
// ****************************************
// Two-entry receive buffer; a full buffer stretches SCL low unless the core is master
// ****************************************
assign rx_push = buf_vld_r;
assign RX_VALID = (fill_r != 2'd0);
assign RX_DATA = buf0_r;
always @(posedge CLOCK)
   if (SRST)
   begin
      fill_r <= 2'd0;
      buf0_r <= 8'h00;
      buf1_r <= 8'h00;
   end
   else if (CE)
   begin
      if (RX_VALID && RX_READY)
      begin
         buf0_r <= (fill_r == 2'd2) ? buf1_r : rx_byte_r;
         if (rx_push && fill_r == 2'd2) buf1_r <= rx_byte_r;
         fill_r <= fill_r - 2'd1 + {1'b0, rx_push};
      end
      else if (rx_push && rx_can)
      begin
         if (fill_r == 2'd0) buf0_r <= rx_byte_r;
         else buf1_r <= rx_byte_r;
         fill_r <= fill_r + 2'd1;
      end
   end
endmodule

// File: sim/tbam_core_assertions.sv
// Port checker for tbam_core: pulse widths, reset state, buffer hold, START generation.
// Assumes it is bound onto tbam_core with CE held high.
`timescale 1ns/1ps
module tbam_core_chk #(
   parameter DW = 8
)(
   input wire logic          CLOCK,
   input wire logic          SRST,
   input wire logic          SCL_IN,
   input wire logic          SCL_OE,
   input wire logic          SDA_IN,
   input wire logic          SDA_OE,
   input wire logic [2:0]    REG_SEL,
   input wire logic          REG_WR,
   input wire logic [DW-1:0] REG_WDATA,
   input wire logic [DW-1:0] REG_RDATA,
   input wire logic          RX_VALID,
   input wire logic          RX_READY,
   input wire logic [DW-1:0] RX_DATA,
   input wire logic          SERIAL_IRQ
);
   logic en_r;
   // Tracks the enable bit of the control register from the write side
   always @(posedge CLOCK)
   begin
      if (SRST)
         en_r <= 1'b0;
      else if (REG_WR && REG_SEL == 3'd3)
         en_r <= REG_WDATA[3];
   end
   // ****************
   // Properties
   // ****************
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SRST);
   sequence s_go;
      REG_WR && REG_SEL == 3'd2 && REG_WDATA == 8'hf0 && en_r && SCL_IN && SDA_IN;
   endsequence
   sequence s_start;
      $rose(SDA_OE) && SCL_IN && !SCL_OE;
   endsequence
   a_irq_pulse: assert property (SERIAL_IRQ |=> !SERIAL_IRQ)
      else $error("interrupt pulse longer than one cycle");
   a_rst_quiet: assert property (disable iff (1'b0) SRST |=> !SERIAL_IRQ && !RX_VALID && !SCL_OE && !SDA_OE)
      else $error("outputs active after reset");
   a_rx_hold: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
      else $error("receive word lost or changed under stall");
   a_stat_shape: assert property (REG_SEL == 3'd2 |-> REG_RDATA[7] == REG_RDATA[6] && !REG_RDATA[3])
      else $error("status layout broken");
   a_start_gen: assert property (s_go |-> ##[1:300] s_start)
      else $error("no START after trigger");
   a_start_hold: assert property (s_start |-> ##[1:100] SCL_OE)
      else $error("clock not driven after START");
   a_idle_quiet: assert property (!en_r |-> !SCL_OE && !SDA_OE)
      else $error("pins driven while disabled");
   a_txbuf_read: assert property (REG_SEL == 3'd6 |-> REG_RDATA == 8'h00)
      else $error("transmit buffer read not zero");
endmodule

// File: sim/tbam_peer.sv
// Behavioural bus master on the far side of the two-wire pins.
// Assumes pull-ups: a released line reads high; honours clock stretching.
`timescale 1ns/1ps
module tbam_peer (
   output logic      scl,
   output logic      sda,
   input  wire logic scl_bus
);
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Bounded wait so a stuck slave cannot hang the run
   task automatic hi_scl;
      scl = 1'b1;
      for (int n = 0; n < 1000 && !scl_bus; n++)
         #10;
   endtask
   task automatic start;
      sda = 1'b1;
      hi_scl();
      #150 sda = 1'b0;
      #150 scl = 1'b0;
   endtask
   // Link clock is 160 ns per bit, stopped between frames
   task automatic put(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         #40 sda = b[i];
         #40 hi_scl();
         #80 scl = 1'b0;
      end
      #40 sda = 1'b1;
   endtask
   task automatic stop;
      #40 sda = 1'b0;
      #40 hi_scl();
      #150 sda = 1'b1;
      #300;
   endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench for tbam_core: slave address match, receive buffer, master START/STOP.
// Assumes rtl/tbam_core.v and sim/tbam_peer.sv compiled first.
`timescale 1ns/1ps
module testbench;
   typedef struct {logic [7:0] ctl, own, adr; logic addressed_as_slave_flag, gc;} row_t;
   logic       CLOCK = 0, SRST = 1, REG_WR = 0, RX_READY = 1;
   logic [2:0] REG_SEL = 3'h0;
   logic [7:0] REG_WDATA = 8'h00, sn, rxq[$];
   wire        SCL_OE, SDA_OE, RX_VALID, SERIAL_IRQ, p_scl, p_sda;
   wire  [7:0] REG_RDATA, RX_DATA;
   wire        scl_bus = ~SCL_OE & p_scl;
   wire        sda_bus = ~SDA_OE & p_sda;
   int         error_cnt = 0, checks = 0, irqn = 0, nb = 9, stp = 0, n;
   time        tr, th;
   row_t       rows [7] = '{
      '{8'h08, 8'ha4, 8'ha4, 1'b1, 1'b0},
      '{8'h08, 8'ha4, 8'ha5, 1'b1, 1'b0},
      '{8'h08, 8'ha4, 8'h00, 1'b0, 1'b1},
      '{8'h08, 8'ha4, 8'h36, 1'b0, 1'b0},
      '{8'h18, 8'ha4, 8'ha5, 1'b0, 1'b0},
      '{8'h18, 8'ha5, 8'ha5, 1'b1, 1'b0},
      '{8'h18, 8'ha4, 8'ha4, 1'b1, 1'b0}};
   tbam_core i_dut (.CLOCK(CLOCK), .SRST(SRST), .CE(1'b1), .SCL_IN(scl_bus), .SCL_OUT(), .SCL_OE(SCL_OE),
      .SDA_IN(sda_bus), .SDA_OUT(), .SDA_OE(SDA_OE), .REG_SEL(REG_SEL), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_DATA(RX_DATA), .SERIAL_IRQ(SERIAL_IRQ));
   tbam_peer i_peer (.scl(p_scl), .sda(p_sda), .scl_bus(scl_bus));
   always #5 CLOCK = ~CLOCK;
   // ****************
   // Monitors
   // ****************
   always @(posedge CLOCK)
   begin
      if (SERIAL_IRQ === 1'b1)
         irqn++;
      if (RX_VALID === 1'b1 && RX_READY)
         rxq.push_back(RX_DATA);
   end
   always @(posedge scl_bus)
   begin
      tr = $time;
      if (nb < 8)
      begin
         sn = {sn[6:0], sda_bus};
         nb++;
      end
   end
   always @(negedge scl_bus) th = $time - tr;
   always @(negedge sda_bus) if (scl_bus) nb = 0;
   always @(posedge sda_bus) if (scl_bus) stp++;
   task automatic finish_test;
      if (error_cnt == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      @(posedge CLOCK);
      REG_SEL <= s;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLOCK);
      REG_WR <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] s, input logic [7:0] e, m);
      @(posedge CLOCK);
      REG_SEL <= s;
      @(negedge CLOCK);
      cmp(REG_RDATA & m, e);
   endtask
   initial
   begin
      #500us;
      error_cnt++;
      finish_test;
   end
   initial
   begin
      repeat (10) @(posedge CLOCK);
      SRST <= 1'b0;
      for (int i = 0; i < 8; i++)
         if (i != 5)
            rd(i[2:0], (i == 2) ? 8'h10 : 8'h00, 8'hff);
      wr(3'd4, 8'h25);
      wr(3'd2, 8'h10);
      foreach (rows[i])
      begin
         wr(3'd1, rows[i].own);
         wr(3'd3, rows[i].ctl);
         irqn = 0;
         i_peer.start();
         i_peer.put(rows[i].adr);
         i_peer.stop();
         cmp(irqn[7:0], 8'd1 + {7'h0, rows[i].addressed_as_slave_flag | rows[i].gc});
         rd(3'd2, {5'h02, rows[i].gc, rows[i].addressed_as_slave_flag, 1'b0}, 8'hf6);
         rd(3'd1, rows[i].own & 8'hfe, 8'hff);
      end
      // Receiver stalls so the third byte has to wait in the pins
      wr(3'd3, 8'h08);
      rxq.delete();
      @(posedge CLOCK);
      RX_READY <= 1'b0;
      fork
         begin
            i_peer.start();
            for (int k = 0; k < 4; k++)
               i_peer.put(k == 0 ? 8'ha4 : 8'h3b + k[7:0]);
            i_peer.stop();
         end
         begin
            #6us;
            @(posedge CLOCK);
            cmp({7'h0, RX_VALID}, 8'h01);
            RX_READY <= 1'b1;
         end
      join
      cmp(8'(rxq.size()), 8'd3);
      for (int k = 0; k < 3; k++)
         cmp(rxq[rxq.size() - 3 + k], 8'h3c + k[7:0]);
      wr(3'd4, 8'h85);
      rd(3'd2, 8'h00, 8'h20);
      wr(3'd6, 8'hb4);
      nb = 9;
      repeat (2) @(posedge CLOCK);
      wr(3'd2, 8'hf0);
      for (n = 0; n < 3000 && nb != 8; n++)
         @(posedge CLOCK);
      cmp({7'h0, n < 3000}, 8'h01);
      cmp(sn, 8'hb4);
      cmp({7'h0, th > 450 && th < 550}, 8'h01);
      stp = 0;
      wr(3'd2, 8'hd0);
      for (n = 0; n < 300 && REG_RDATA[5] !== 1'b0; n++)
         repeat (20) @(posedge CLOCK);
      cmp({7'h0, n < 300}, 8'h01);
      cmp(stp[7:0], 8'h01);
      rd(3'd2, 8'h00, 8'he0);
      finish_test;
   end
endmodule
bind tbam_core tbam_core_chk #(.DW(DW)) i_chk (.CLOCK(CLOCK), .SRST(SRST), .SCL_IN(SCL_IN), .SCL_OE(SCL_OE),
   .SDA_IN(SDA_IN), .SDA_OE(SDA_OE), .REG_SEL(REG_SEL), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
   .REG_RDATA(REG_RDATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_DATA(RX_DATA), .SERIAL_IRQ(SERIAL_IRQ));
